//--- rtl/dsd_decode.sv
`timescale 1ns/100ps
module dsd_decode (
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    // instruction issue
    input  wire logic        instValid,
    output logic             instReady,
    input  wire logic [15:0] instWord1,
    input  wire logic [15:0] instWord2,
    input  wire logic [31:0] instAddr,
    input  wire logic        inDelaySlot,
    input  wire logic        branchClass,
    input  wire logic        dspConditionFlag,
    input  wire logic [31:0] dspDestData,
    input  wire logic        memWait,
    output logic             execDone,
    output logic [31:0]      pcValue,
    output logic             dspWrEn,
    output logic [3:0]       dspWrIdx,
    output logic [31:0]      dspWrData,
    output logic             xMoveEn,
    output logic             yMoveEn,
    output logic             illegalInst,
    output logic             illegalSlot,
    // data access checking
    input  wire logic        memReq,
    input  wire logic        memWrite,
    input  wire logic [1:0]  memSize,
    input  wire logic [31:0] memAddr,
    output logic             addrErrRead,
    output logic             addrErrWrite,
    output logic             irq,
    // register bus
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);

    typedef struct packed {
        dsd_pkg::dsd_exec_type          exec;
        logic                           instReady;
        logic                           execDone;
        logic [31:0]                    pcValue;
        logic [31:0]                    accHigh;
        logic [31:0]                    accLow;
        logic [31:0]                    statusWord;
        logic [31:0]                    cycleCount;
        logic [dsd_pkg::EVT_WIDTH-1:0]  evtStatus;
        logic [dsd_pkg::EVT_WIDTH-1:0]  evtMask;
        logic                           dspWrEn;
        logic [3:0]                     dspWrIdx;
        logic [31:0]                    dspWrData;
        logic                           xMoveEn;
        logic                           yMoveEn;
        logic                           illegalInst;
        logic                           illegalSlot;
        logic                           addrErrRead;
        logic                           addrErrWrite;
        logic                           irq;
        logic [7:0]                     awAddr;
        logic                           awHave;
        logic [31:0]                    wData;
        logic [3:0]                     wStrb;
        logic                           wHave;
        logic                           awReady;
        logic                           wReady;
        logic                           bValid;
        logic [1:0]                     bResp;
        logic                           arReady;
        logic                           rValid;
        logic [31:0]                    rData;
        logic [1:0]                     rResp;
    } dsd_state_type;

    dsd_state_type r_q;
    dsd_state_type r_d;

    // byte-lane merge for partial writes
    function automatic logic [31:0] mergeStrobe(input logic [31:0] old,
                                                input logic [31:0] val,
                                                input logic [3:0]  strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = val[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // decode terms, all combinational from the issue port, the data access port, the registered instReady and the write-channel state
    logic        accept;
    logic        isDsp;
    logic        isSys;
    logic        sysLoad;
    logic        sysLow;
    logic [1:0]  sysCond;
    logic        sysWellFormed;
    logic        condPass;
    logic        isXyWord;
    logic        misalign;
    logic        swWrite;

    assign accept        = instValid && r_q.instReady;
    assign isDsp         = instWord1[15:10] == dsd_pkg::DSP_PREFIX;
    assign isSys         = isDsp && instWord2[15:14] == dsd_pkg::SYS_GROUP
                           && instWord2[11:10] == dsd_pkg::SYS_GROUP;
    assign sysLoad       = instWord2[13];
    assign sysLow        = instWord2[12];
    assign sysCond       = instWord2[9:8];
    assign sysWellFormed = isSys && sysCond != 2'h0 && instWord2[7:4] == 4'h0;
    // the condition flag is only read here, never written
    assign condPass      = (sysCond == dsd_pkg::COND_ALWAYS)
                           || (sysCond == dsd_pkg::COND_TRUE && dspConditionFlag)
                           || (sysCond == dsd_pkg::COND_FALSE && !dspConditionFlag);
    // one field position serves both the dsp and the transfer-only forms
    assign isXyWord      = instWord1[15:12] == dsd_pkg::XY_PREFIX
                           && (isDsp || instWord1[11:10] == dsd_pkg::XY_ONLY_SEL);
    assign misalign      = (memSize == dsd_pkg::SIZE_WORD && memAddr[0])
                           || (memSize == dsd_pkg::SIZE_LONG && memAddr[1:0] != 2'h0);
    assign swWrite       = r_q.awHave && r_q.wHave && !r_q.bValid;

    // next state: execution, event capture and bus slave
    always_comb begin
        logic [dsd_pkg::EVT_WIDTH-1:0] evtSet;
        logic [dsd_pkg::EVT_WIDTH-1:0] evtClr;
        logic                          mapped;
        evtSet = '0;
        evtClr = '0;
        mapped = 1'b0;
        r_d = r_q;
        r_d.execDone     = 1'b0;
        r_d.dspWrEn      = 1'b0;
        r_d.illegalInst  = 1'b0;
        r_d.illegalSlot  = 1'b0;
        r_d.addrErrRead  = 1'b0;
        r_d.addrErrWrite = 1'b0;
        // execution sequencing; waits delay the done pulse and hold instReady low
        case (r_q.exec)
            dsd_pkg::ST_IDLE: begin
                if (accept) begin
                    r_d.cycleCount = r_q.cycleCount + dsd_pkg::TABLE_CYCLES;
                    if (memWait) begin
                        r_d.exec      = dsd_pkg::ST_WAIT;
                        r_d.instReady = 1'b0;
                    end else begin
                        r_d.execDone = 1'b1;
                    end
                end
            end
            dsd_pkg::ST_WAIT: begin
                if (!memWait) begin
                    r_d.exec      = dsd_pkg::ST_IDLE;
                    r_d.instReady = 1'b1;
                    r_d.execDone  = 1'b1;
                end
            end
            default: begin
                r_d.exec      = dsd_pkg::ST_IDLE;
                r_d.instReady = 1'b1;
            end
        endcase

        // software side of the register file, taken before instruction effects
        if (swWrite) begin
            r_d.bValid = 1'b1;
            r_d.bResp  = dsd_pkg::RESP_OKAY;
            r_d.awHave = 1'b0;
            r_d.wHave  = 1'b0;
            case (r_q.awAddr)
                dsd_pkg::OFS_STATUS_WORD:
                    r_d.statusWord = mergeStrobe(r_q.statusWord, r_q.wData, r_q.wStrb)
                                     & dsd_pkg::SW_IMPL_MASK;
                dsd_pkg::OFS_ACC_HIGH:
                    r_d.accHigh = mergeStrobe(r_q.accHigh, r_q.wData, r_q.wStrb);
                dsd_pkg::OFS_ACC_LOW:
                    r_d.accLow = mergeStrobe(r_q.accLow, r_q.wData, r_q.wStrb);
                dsd_pkg::OFS_EVT_STATUS:
                    evtClr = r_q.wStrb[0] ? r_q.wData[dsd_pkg::EVT_WIDTH-1:0] : '0;
                dsd_pkg::OFS_EVT_MASK:
                    r_d.evtMask = r_q.wStrb[0] ? r_q.wData[dsd_pkg::EVT_WIDTH-1:0] : r_q.evtMask;
                dsd_pkg::OFS_CYCLE_COUNT, dsd_pkg::OFS_PC_VALUE:
                    r_d.bResp = dsd_pkg::RESP_OKAY; // read-only, write ignored
                default:
                    r_d.bResp = dsd_pkg::RESP_SLVERR;
            endcase
        end

        // instruction effects override a same-cycle software write
        if (accept) begin
            r_d.pcValue = instAddr + dsd_pkg::PC_OFFSET;
            r_d.xMoveEn = isXyWord && instWord1[7:6] != 2'h0;
            r_d.yMoveEn = isXyWord && instWord1[5:4] != 2'h0;
            if (inDelaySlot && (branchClass || instWord1 == dsd_pkg::ILLEGAL_CODE)) begin
                r_d.illegalSlot = 1'b1;
                evtSet[dsd_pkg::EVT_ILL_SLOT] = 1'b1;
            end else if (instWord1 == dsd_pkg::ILLEGAL_CODE || (isSys && !sysWellFormed)) begin
                r_d.illegalInst = 1'b1;
                evtSet[dsd_pkg::EVT_ILL_INST] = 1'b1;
            end else if (sysWellFormed && condPass) begin
                // a failed condition falls through with nothing touched
                if (sysLoad && !sysLow) begin
                    r_d.accHigh = dspDestData;
                end else if (sysLoad) begin
                    r_d.accLow = dspDestData;
                end else begin
                    r_d.dspWrEn   = 1'b1;
                    r_d.dspWrIdx  = instWord2[3:0];
                    r_d.dspWrData = sysLow ? r_q.accLow : r_q.accHigh;
                end
            end
        end

        // alignment check on every data access
        if (memReq && misalign) begin
            if (memWrite) begin
                r_d.addrErrWrite = 1'b1;
                evtSet[dsd_pkg::EVT_ADDR_WR] = 1'b1;
            end else begin
                r_d.addrErrRead = 1'b1;
                evtSet[dsd_pkg::EVT_ADDR_RD] = 1'b1;
            end
        end

        // set wins over a write-one-to-clear in the same cycle
        r_d.evtStatus = (r_q.evtStatus & ~evtClr) | evtSet;
        r_d.irq       = |(r_d.evtStatus & r_d.evtMask);

        // write channels accepted independently, one write in flight
        r_d.awReady = !r_d.awHave && !r_d.bValid;
        r_d.wReady  = !r_d.wHave && !r_d.bValid;
        if (s_axi_awvalid && r_q.awReady) begin
            r_d.awAddr  = s_axi_awaddr;
            r_d.awHave  = 1'b1;
            r_d.awReady = 1'b0;
        end
        if (s_axi_wvalid && r_q.wReady) begin
            r_d.wData  = s_axi_wdata;
            r_d.wStrb  = s_axi_wstrb;
            r_d.wHave  = 1'b1;
            r_d.wReady = 1'b0;
        end
        if (r_q.bValid && s_axi_bready) begin
            r_d.bValid  = 1'b0;
            r_d.awReady = !r_q.awHave;
            r_d.wReady  = !r_q.wHave;
        end

        // read channel: answer one cycle after the address is taken
        if (s_axi_arvalid && r_q.arReady) begin
            r_d.arReady = 1'b0;
            r_d.rValid  = 1'b1;
            r_d.rResp   = dsd_pkg::RESP_OKAY;
            mapped      = 1'b1;
            case (s_axi_araddr)
                dsd_pkg::OFS_STATUS_WORD: r_d.rData = r_q.statusWord & dsd_pkg::SW_IMPL_MASK;
                dsd_pkg::OFS_ACC_HIGH:    r_d.rData = r_q.accHigh;
                dsd_pkg::OFS_ACC_LOW:     r_d.rData = r_q.accLow;
                dsd_pkg::OFS_EVT_STATUS:  r_d.rData = {28'h0000000, r_q.evtStatus};
                dsd_pkg::OFS_EVT_MASK:    r_d.rData = {28'h0000000, r_q.evtMask};
                dsd_pkg::OFS_CYCLE_COUNT: r_d.rData = r_q.cycleCount;
                dsd_pkg::OFS_PC_VALUE:    r_d.rData = r_q.pcValue;
                default:                  mapped    = 1'b0;
            endcase
            if (!mapped) begin
                r_d.rData = 32'h00000000;
                r_d.rResp = dsd_pkg::RESP_SLVERR;
            end
        end
        if (r_q.rValid && s_axi_rready) begin
            r_d.rValid  = 1'b0;
            r_d.arReady = 1'b1;
        end
    end
    // single state register, synchronous active-low reset
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            r_q            <= '0;
            r_q.exec       <= dsd_pkg::ST_IDLE;
            r_q.instReady  <= 1'b1;
            r_q.statusWord <= dsd_pkg::SW_RESET;
            r_q.awReady    <= 1'b1;
            r_q.wReady     <= 1'b1;
            r_q.arReady    <= 1'b1;
        end else begin
            r_q <= r_d;
        end
    end

    assign instReady     = r_q.instReady;
    assign execDone      = r_q.execDone;
    assign pcValue       = r_q.pcValue;
    assign dspWrEn       = r_q.dspWrEn;
    assign dspWrIdx      = r_q.dspWrIdx;
    assign dspWrData     = r_q.dspWrData;
    assign xMoveEn       = r_q.xMoveEn;
    assign yMoveEn       = r_q.yMoveEn;
    assign illegalInst   = r_q.illegalInst;
    assign illegalSlot   = r_q.illegalSlot;
    assign addrErrRead   = r_q.addrErrRead;
    assign addrErrWrite  = r_q.addrErrWrite;
    assign irq           = r_q.irq;
    assign s_axi_awready = r_q.awReady;
    assign s_axi_wready  = r_q.wReady;
    assign s_axi_bvalid  = r_q.bValid;
    assign s_axi_bresp   = r_q.bResp;
    assign s_axi_arready = r_q.arReady;
    assign s_axi_rvalid  = r_q.rValid;
    assign s_axi_rdata   = r_q.rData;
    assign s_axi_rresp   = r_q.rResp;
    // checks on the decode and execution behaviour
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    a_load_high: assert property (accept && !inDelaySlot && sysWellFormed && sysLoad
        && !sysLow && condPass |=> r_q.accHigh == $past(dspDestData))
        else $error("accumulator high not loaded");
    a_cond_true: assert property (accept && sysWellFormed && sysLoad && !swWrite
        && sysCond == dsd_pkg::COND_TRUE && !dspConditionFlag
        |=> $stable(r_q.accHigh) && $stable(r_q.accLow))
        else $error("true-conditional load not suppressed");
    a_cond_false: assert property (accept && sysWellFormed && sysLoad && !swWrite
        && sysCond == dsd_pkg::COND_FALSE && dspConditionFlag
        |=> $stable(r_q.accHigh) && $stable(r_q.accLow))
        else $error("false-conditional load not suppressed");
    a_store_value: assert property (accept && !inDelaySlot && sysWellFormed && !sysLoad
        && condPass |=> dspWrEn && dspWrIdx == $past(instWord2[3:0])
        && dspWrData == ($past(sysLow) ? $past(r_q.accLow) : $past(r_q.accHigh)))
        else $error("accumulator store wrong");
    a_store_suppress: assert property (accept && sysWellFormed && !sysLoad
        && !condPass |=> !dspWrEn)
        else $error("suppressed store wrote destination");
    a_one_cycle: assert property (accept && !memWait |=> execDone
        ##1 (!execDone || $past(accept)))
        else $error("execution not one cycle");
    a_wait_stall: assert property (accept && memWait |=> !execDone && !instReady)
        else $error("wait state did not lengthen execution");
    a_idle_y: assert property (accept && isXyWord && instWord1[5:4] == 2'h0
        |=> !yMoveEn)
        else $error("zero y field moved");
    a_idle_x: assert property (accept && isXyWord && instWord1[7:6] == 2'h0
        |=> !xMoveEn)
        else $error("zero x field moved");
    a_addr_read: assert property (memReq && !memWrite && misalign
        |=> addrErrRead && r_q.evtStatus[dsd_pkg::EVT_ADDR_RD])
        else $error("misaligned read not flagged");
    a_addr_write: assert property (memReq && memWrite
        && memSize == dsd_pkg::SIZE_LONG && memAddr[1:0] != 2'h0 |=> addrErrWrite)
        else $error("misaligned write not flagged");
    a_slot_branch: assert property (accept && inDelaySlot && branchClass
        |=> illegalSlot && !illegalInst)
        else $error("illegal slot not flagged");
    a_pc_offset: assert property (accept |=> pcValue == $past(instAddr) + 32'h00000004)
        else $error("pc offset wrong");
    a_status_unused: assert property ((r_q.statusWord & ~dsd_pkg::SW_IMPL_MASK) == '0)
        else $error("unused status bits set");
    a_illegal_code: assert property (accept && !inDelaySlot
        && instWord1 == dsd_pkg::ILLEGAL_CODE |=> illegalInst)
        else $error("illegal code not flagged");
    a_irq_level: assert property (irq == |(r_q.evtStatus & r_q.evtMask))
        else $error("interrupt level wrong");
    c_cond_load: cover property (accept && sysWellFormed && sysLoad && condPass);
    c_cond_skip: cover property (accept && sysWellFormed && !condPass);
    c_store_wait: cover property (accept && sysWellFormed && !sysLoad && memWait);
    c_slot_error: cover property (illegalSlot ##[1:4] irq);
endmodule // dsd_decode

//--- rtl/dsd_pkg.sv
package dsd_pkg;
    // register byte offsets on the control bus
    localparam logic [7:0]  OFS_STATUS_WORD = 8'h00;
    localparam logic [7:0]  OFS_ACC_HIGH    = 8'h04;
    localparam logic [7:0]  OFS_ACC_LOW     = 8'h08;
    localparam logic [7:0]  OFS_EVT_STATUS  = 8'h0c;
    localparam logic [7:0]  OFS_EVT_MASK    = 8'h10;
    localparam logic [7:0]  OFS_CYCLE_COUNT = 8'h14;
    localparam logic [7:0]  OFS_PC_VALUE    = 8'h18;

    // status word field positions, lsb upward
    localparam int          SW_TEST_BIT    = 0;
    localparam int          SW_SATURATE    = 1;
    localparam int          SW_REPEAT_ZERO = 2;
    localparam int          SW_REPEAT_ONE  = 3;
    localparam int          SW_IMASK_LSB   = 4;
    localparam int          SW_DIV_Q       = 8;
    localparam int          SW_DIV_M       = 9;
    localparam int          SW_X_MODULO    = 10;
    localparam int          SW_Y_MODULO    = 11;
    localparam int          SW_LOOP_LSB    = 16;
    localparam logic [31:0] SW_IMPL_MASK   = 32'h0fff0fff;
    localparam logic [31:0] SW_RESET       = 32'h000000f0;

    // event bits, shared by status and mask registers
    localparam int          EVT_ADDR_RD    = 0;
    localparam int          EVT_ADDR_WR    = 1;
    localparam int          EVT_ILL_SLOT   = 2;
    localparam int          EVT_ILL_INST   = 3;
    localparam int          EVT_WIDTH      = 4;

    // instruction encodings
    localparam logic [5:0]  DSP_PREFIX     = 6'h3e;
    localparam logic [3:0]  XY_PREFIX      = 4'hf;
    localparam logic [1:0]  XY_ONLY_SEL    = 2'h0;
    localparam logic [1:0]  SYS_GROUP      = 2'h3;
    localparam logic [1:0]  COND_ALWAYS    = 2'h1;
    localparam logic [1:0]  COND_TRUE      = 2'h2;
    localparam logic [1:0]  COND_FALSE     = 2'h3;
    localparam logic [15:0] ILLEGAL_CODE   = 16'hffff;
    localparam logic [31:0] PC_OFFSET      = 32'h00000004;
    localparam logic [31:0] TABLE_CYCLES   = 32'h00000001;

    // memory access sizes
    localparam logic [1:0]  SIZE_BYTE      = 2'h0;
    localparam logic [1:0]  SIZE_WORD      = 2'h1;
    localparam logic [1:0]  SIZE_LONG      = 2'h2;

    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;

    typedef enum logic [0:0] {ST_IDLE, ST_WAIT} dsd_exec_type;
endpackage

//--- dv/tb_top.sv
`timescale 1ns/100ps
// one compare point: counts every check and reports a mismatch at once
`define CHK(g,e) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
    logic        clk_sys = 0, nrst = 0, instValid = 0, inDelaySlot = 0, branchClass = 0;
    logic        dspConditionFlag = 0, memWait = 0, memReq = 0, memWrite = 0, watch = 0;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0;
    logic [15:0] instWord1 = 0, instWord2 = 0;
    logic [31:0] instAddr = 0, dspDestData = 0, memAddr = 0, s_axi_wdata = 0;
    logic [31:0] accH = 0, accL = 0, a, d, p, m;
    logic [1:0]  memSize = 0;
    logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [3:0]  s_axi_wstrb = 0, x;
    wire logic   instReady, execDone, dspWrEn, xMoveEn, yMoveEn, illegalInst, illegalSlot;
    wire logic   addrErrRead, addrErrWrite, irq, s_axi_awready, s_axi_wready, s_axi_bvalid;
    wire logic   s_axi_arready, s_axi_rvalid;
    wire logic [31:0] pcValue, dspWrData, s_axi_rdata;
    wire logic [3:0]  dspWrIdx;
    wire logic [1:0]  s_axi_bresp, s_axi_rresp;
    int          error_cnt = 0, tests_run = 0, n = 0, i;
    logic [63:0] q[$];
    bit          act, sto;
    logic [36:0] st = 0;
    dsd_decode DUT (.*);
    always #25 clk_sys = ~clk_sys;
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // a wait that ran out of its bound ends the run
    task automatic to(int k);
        if (k >= 60) begin error_cnt++; tally_and_finish(); end
    endtask
    task automatic pop(logic [63:0] g);
        logic [63:0] e;
        e = (q.size() == 0) ? 'x : q.pop_front();
        `CHK(g, e)
    endtask
    task automatic wr(logic [7:0] ad, logic [31:0] dt, logic [1:0] rs = 2'h0);
        q.push_back({32'hb0, 30'h0, rs});
        @(posedge clk_sys);
        s_axi_awaddr <= ad; s_axi_wdata <= dt; s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
        for (i = 0; i < 60; i++) begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 0; to(i);
    endtask
    task automatic rd(logic [7:0] ad, logic [1:0] rs, logic [31:0] dt);
        q.push_back({30'h0, rs, dt});
        @(posedge clk_sys);
        s_axi_araddr <= ad; s_axi_arvalid <= 1; s_axi_rready <= 1;
        for (i = 0; i < 60; i++) begin
            @(posedge clk_sys);
            if (s_axi_arready) s_axi_arvalid <= 0;
            if (s_axi_rvalid) break;
        end
        s_axi_rready <= 0; to(i);
    endtask
    // wt stretches execution with memory waits; wd says a completion pulse is due
    task automatic iss(logic [15:0] w1, w2, logic [31:0] ad, dd, bit f, wt, wd);
        @(posedge clk_sys);
        instValid <= 1; instWord1 <= w1; instWord2 <= w2; instAddr <= ad;
        dspConditionFlag <= f; dspDestData <= dd; memWait <= wt;
        for (i = 0; i < 60; i++) begin @(posedge clk_sys); if (instReady) break; end
        to(i); instValid <= 0; n++;
        repeat (wt ? 3 : 0) @(posedge clk_sys);
        memWait <= 0;
        if (wd) begin
            for (i = 0; i < 60; i++) begin @(posedge clk_sys); if (execDone) break; end
            to(i);
        end else repeat (3) @(posedge clk_sys);
    endtask
    // observer: every result seen at the ports takes the oldest expectation
    always @(posedge clk_sys) begin
        if (s_axi_rvalid && s_axi_rready) pop({30'h0, s_axi_rresp, s_axi_rdata});
        if (s_axi_bvalid && s_axi_bready) pop({32'hb0, 30'h0, s_axi_bresp});
        // a store stretched by waits writes back before its completion pulse
        if (dspWrEn) st = {1'b1, dspWrIdx, dspWrData};
        if (watch && execDone) begin
            pop({pcValue[24:0], st[35:32], xMoveEn, yMoveEn, st[36], st[31:0]});
            st = '0;
        end
        if (addrErrRead || addrErrWrite) pop({32'hae, 30'h0, addrErrWrite, addrErrRead});
        if (illegalInst || illegalSlot) pop({32'h1e, 30'h0, illegalSlot, illegalInst});
    end
    initial begin
        m = $urandom(32'h1912);
        repeat (20) @(posedge clk_sys);
        nrst <= 1;
        rd(dsd_pkg::OFS_STATUS_WORD, dsd_pkg::RESP_OKAY, dsd_pkg::SW_RESET);
        wr(dsd_pkg::OFS_STATUS_WORD, 32'hffffffff);
        rd(dsd_pkg::OFS_STATUS_WORD, dsd_pkg::RESP_OKAY, dsd_pkg::SW_IMPL_MASK);
        rd(8'h40, dsd_pkg::RESP_SLVERR, 32'h0);
        wr(8'h40, 32'h0, dsd_pkg::RESP_SLVERR);
        watch = 1;
        // loads first so that the stores return known accumulator values
        for (int l = 1; l >= 0; l--) for (int h = 0; h < 2; h++)
            for (int c = 1; c < 4; c++) for (int f = 0; f < 2; f++) begin
                a = $urandom & 32'h00fffffc; d = $urandom; x = 4'($urandom); p = a + 32'h4;
                act = (c == 1) || (c == 2 && f == 1) || (c == 3 && f == 0);
                sto = !l && act;
                q.push_back({p[24:0], sto ? x : 4'h0, 2'b00, sto,
                    sto ? (h ? accL : accH) : 32'h0});
                iss({16'hf800}, {2'b11, l[0], h[0], 2'b11, c[1:0], 4'h0, x}, a, d, f[0],
                    ($urandom % 4) == 0, 1);
                if (l && act && h) accL = d;
                if (l && act && !h) accH = d;
                if (l) rd(h ? dsd_pkg::OFS_ACC_LOW : dsd_pkg::OFS_ACC_HIGH,
                    dsd_pkg::RESP_OKAY, h ? accL : accH);
            end
        // idle transfer fields: Y only, X only, both idle
        for (int k = 0; k < 3; k++) begin
            m = {16'h0, k == 0 ? 16'hf080 : k == 1 ? 16'hf030 : 16'hf800};
            a = $urandom & 32'h00fffffc; p = a + 32'h4;
            q.push_back({p[24:0], 4'h0, m[7:6] != 0, m[5:4] != 0, 33'h0});
            iss(m[15:0], 16'h0, a, 32'h0, 0, 0, 1);
        end
        rd(dsd_pkg::OFS_CYCLE_COUNT, dsd_pkg::RESP_OKAY, n);
        rd(dsd_pkg::OFS_PC_VALUE, dsd_pkg::RESP_OKAY, p);
        watch = 0;
        wr(dsd_pkg::OFS_EVT_MASK, 32'h0);
        for (int w = 0; w < 2; w++) for (int s = 0; s < 3; s++) for (int o = 0; o < 4; o++) begin
            @(posedge clk_sys);
            m = $urandom;
            memReq <= 1; memWrite <= w[0]; memSize <= s[1:0]; memAddr <= {m[31:2], o[1:0]};
            if ((s == 1 && o[0]) || (s == 2 && o != 0))
                q.push_back({32'hae, 30'h0, w[0], !w[0]});
        end
        @(posedge clk_sys);
        memReq <= 0;
        repeat (3) @(posedge clk_sys);
        `CHK(irq, 1'b0)
        wr(dsd_pkg::OFS_EVT_MASK, 32'h1);
        repeat (3) @(posedge clk_sys);
        `CHK(irq, 1'b1)
        rd(dsd_pkg::OFS_EVT_STATUS, dsd_pkg::RESP_OKAY, 32'h3);
        wr(dsd_pkg::OFS_EVT_STATUS, 32'h3);
        repeat (3) @(posedge clk_sys);
        `CHK(irq, 1'b0)
        q.push_back({32'h1e, 30'h0, 2'b01});
        iss(16'hf800, 16'hec15, 32'h100, 32'h0, 0, 0, 0);
        q.push_back({32'h1e, 30'h0, 2'b01});
        iss(dsd_pkg::ILLEGAL_CODE, 16'h0, 32'h104, 32'h0, 0, 0, 0);
        inDelaySlot <= 1; branchClass <= 1;
        q.push_back({32'h1e, 30'h0, 2'b10});
        iss(16'h000b, 16'h0, 32'h108, 32'h0, 0, 0, 0);
        inDelaySlot <= 0; branchClass <= 0;
        rd(dsd_pkg::OFS_EVT_STATUS, dsd_pkg::RESP_OKAY, 32'hc);
        tally_and_finish();
    end
endmodule // tb_top
